/* core/flash_regs_pkg.sv */
// Constants shared by the flash status and configuration register bank.
// Assumes a 100 MHz core clock; all times are converted to cycles here.
package flash_regs_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int REGS_TIME_NS  = 2000;
    localparam int PROG_TIME_NS  = 8000;
    localparam int ERASE_TIME_NS = 30000;

    localparam logic [11:0] REGS_CYCLES  = 12'((REGS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] PROG_CYCLES  = 12'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] ERASE_CYCLES = 12'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // First status register fields
    localparam int S1_DISABLE  = 7;
    localparam int S1_PROT_HI  = 4;
    localparam int S1_PROT_LO  = 2;
    // Configuration register fields
    localparam int C1_LAT_HI   = 7;
    localparam int C1_LAT_LO   = 6;
    localparam int C1_ORIGIN   = 5;
    localparam int C1_VOLATILE = 3;
    localparam int C1_PARAM    = 2;
    localparam int C1_QUAD     = 1;
    localparam int C1_FREEZE   = 0;
    // Second status register fields
    localparam int S2_OTP_HI   = 7;
    localparam int S2_OTP_LO   = 5;

    localparam logic [2:0] PROT_RESET     = 3'h0;
    localparam logic [2:0] PROT_VOL_RESET = 3'h7;
    localparam logic [7:0] CONFIG_RESET   = 8'h00;
    localparam logic [2:0] S2_OTP_RESET   = 3'h0;

    localparam logic [24:0] ARRAY_SIZE = 25'h1000000;

    localparam logic [7:0] CMD_WRITE_REGS  = 8'h01;
    localparam logic [7:0] CMD_PROGRAM     = 8'h02;
    localparam logic [7:0] CMD_WRITE_DIS   = 8'h04;
    localparam logic [7:0] CMD_READ_S1     = 8'h05;
    localparam logic [7:0] CMD_WRITE_EN    = 8'h06;
    localparam logic [7:0] CMD_READ_S2     = 8'h07;
    localparam logic [7:0] CMD_CLEAR_ERR   = 8'h30;
    localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
    localparam logic [7:0] CMD_SUSPEND     = 8'h75;
    localparam logic [7:0] CMD_RESUME      = 8'h7a;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] CMD_SOFT_RESET  = 8'hf0;

    typedef enum logic [1:0] {OP_NONE, OP_REGS, OP_PROG, OP_ERASE} op_kind_t;

endpackage

/* core/spi_byte_port.sv */
// Serial front end: synchronises the pins, finds clock edges, moves bytes.
// Assumes mode 0 with the serial clock well below a quarter of the core clock.
`timescale 1ns/1ps
module spi_byte_port (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       mosi,
    input  wire logic       wpN,
    input  wire logic [7:0] txByte,
    output logic      [7:0] rxByte,
    output logic            rxValid,
    output logic            frameEnd,
    output logic            wpLevel,
    output logic            miso,
    output logic            misoOe
);
    logic [3:0] pinIn;
    logic [3:0] meta;
    logic [3:0] stable;
    logic       sclkPrev;
    logic       csPrev;
    logic [2:0] bitCnt;
    logic [6:0] rxShift;
    logic [6:0] txShift;
    logic       rise;
    logic       fall;

    assign pinIn = {wpN, mosi, csN, sclk};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : sync
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    meta[g]   <= 1'b1;
                    stable[g] <= 1'b1;
                end else begin
                    meta[g]   <= pinIn[g];
                    stable[g] <= meta[g];
                end
            end
        end
    endgenerate

    // Edges are only taken while selected, so a stray clock is harmless
    assign rise = stable[0] & ~sclkPrev & ~stable[1];
    assign fall = ~stable[0] & sclkPrev & ~stable[1];
    assign wpLevel = stable[3];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclkPrev <= 1'b0;
            csPrev   <= 1'b1;
            frameEnd <= 1'b0;
        end else begin
            sclkPrev <= stable[0];
            csPrev   <= stable[1];
            frameEnd <= stable[1] & ~csPrev;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bitCnt  <= 3'h0;
            rxShift <= 7'h00;
            rxByte  <= 8'h00;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (stable[1]) begin
                bitCnt <= 3'h0;
            end else if (rise) begin
                rxShift <= {rxShift[5:0], stable[2]};
                bitCnt  <= bitCnt + 3'h1;
                if (bitCnt == 3'h7) begin
                    rxByte  <= {rxShift, stable[2]};
                    rxValid <= 1'b1;
                end
            end
        end
    end

    // A new byte is loaded on the falling edge that follows each whole byte
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            miso    <= 1'b0;
            misoOe  <= 1'b0;
            txShift <= 7'h00;
        end else begin
            misoOe <= ~stable[1];
            if (fall) begin
                if (bitCnt == 3'h0) begin
                    miso    <= txByte[7];
                    txShift <= txByte[6:0];
                end else begin
                    miso    <= txShift[6];
                    txShift <= {txShift[5:0], 1'b0};
                end
            end
        end
    end

endmodule

/* core/flash_status_regs.sv */
// Status and configuration register bank of a serial NOR flash.
// Assumes the array lies outside and reports a failed operation on opFail.
`timescale 1ns/1ps
module flash_status_regs
    import flash_regs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        mosi,
    input  wire logic        wpN,
    input  wire logic        opFail,
    output logic             miso,
    output logic             misoOe,
    output logic             busy,
    output logic             quadEnable,
    output logic       [1:0] latencyCode,
    output logic             protectOriginLow,
    output logic             paramSectorsTop,
    output logic             otpLocked,
    output logic             uniformErase,
    output logic             pageWrap512,
    output logic             line3ResetFunction,
    output logic             arrayWrite,
    output logic             arrayStart,
    output logic             arrayEraseOp,
    output logic      [23:0] arrayAddr,
    output logic       [7:0] arrayData
);
    logic [7:0]  rxByte;
    logic        rxValid;
    logic        frameEnd;
    logic        wpLevel;
    logic [7:0]  txByte;
    logic [7:0]  cmdReg;
    logic [2:0]  byteIdx;
    logic [23:0] addrReg;
    logic [23:0] wrAddrReg;
    logic [7:0]  dataOne;
    logic [7:0]  dataTwo;
    logic [7:0]  dataThree;
    logic        disableReg;
    logic        progErrReg;
    logic        eraseErrReg;
    logic [2:0]  protReg;
    logic        welReg;
    logic [7:0]  configReg;
    logic [2:0]  s2OtpReg;
    logic        eraseSuspReg;
    logic        progSuspReg;
    op_kind_t    opKind;
    logic [11:0] countReg;
    logic [7:0]  statusOne;
    logic [7:0]  statusTwo;
    logic        writeReady;
    logic        progHit;
    logic        eraseHit;
    logic [23:0] eraseAddr;
    logic        endCmd;
    logic        regsGo;
    logic        progCmd;
    logic        eraseCmd;
    logic        progGo;
    logic        eraseGo;
    logic        opDone;
    logic        suspendGo;
    logic        resumeGo;
    logic        softGo;
    logic        clearGo;

    spi_byte_port port (
        .clock    (clock),
        .reset    (reset),
        .sclk     (sclk),
        .csN      (csN),
        .mosi     (mosi),
        .wpN      (wpN),
        .txByte   (txByte),
        .rxByte   (rxByte),
        .rxValid  (rxValid),
        .frameEnd (frameEnd),
        .wpLevel  (wpLevel),
        .miso     (miso),
        .misoOe   (misoOe)
    );

    function automatic logic inRange(input logic [23:0] a, input logic [2:0] bp, input logic low);
        logic [24:0] size;
        size = ARRAY_SIZE >> (3'h7 - bp);
        if (bp == 3'h0) begin
            inRange = 1'b0;
        end else if (low) begin
            inRange = {1'b0, a} < size;
        end else begin
            inRange = {1'b0, a} >= ARRAY_SIZE - size;
        end
    endfunction

    assign quadEnable         = configReg[C1_QUAD];
    assign latencyCode        = configReg[C1_LAT_HI:C1_LAT_LO];
    assign protectOriginLow   = configReg[C1_ORIGIN];
    assign paramSectorsTop    = configReg[C1_PARAM];
    assign otpLocked          = configReg[C1_FREEZE];
    assign uniformErase       = s2OtpReg[2];
    assign pageWrap512        = s2OtpReg[1];
    assign line3ResetFunction = s2OtpReg[0];

    assign statusOne = {disableReg, progErrReg, eraseErrReg, protReg, welReg, busy};
    assign statusTwo = {s2OtpReg, 3'h0, eraseSuspReg, progSuspReg};

    always_comb begin
        unique case (cmdReg)
            CMD_READ_S1:     txByte = statusOne;
            CMD_READ_CONFIG: txByte = configReg;
            CMD_READ_S2:     txByte = statusTwo;
            default:         txByte = 8'h00;
        endcase
    end

    // A suspended operation still owns the timer, so no new array work starts
    assign writeReady = welReg && !busy && opKind == OP_NONE;
    assign eraseAddr  = uniformErase ? {addrReg[23:18], 18'h0} : {addrReg[23:16], 16'h0};
    assign progHit    = inRange(addrReg, protReg, configReg[C1_ORIGIN]);
    assign eraseHit   = inRange(eraseAddr, protReg, configReg[C1_ORIGIN]);
    assign endCmd     = frameEnd && byteIdx == 3'h1;
    assign regsGo     = frameEnd && cmdReg == CMD_WRITE_REGS && byteIdx >= 3'h2 && writeReady
                        && !(disableReg && !wpLevel);
    assign progCmd    = frameEnd && cmdReg == CMD_PROGRAM && byteIdx >= 3'h5 && writeReady;
    assign eraseCmd   = frameEnd && cmdReg == CMD_BLOCK_ERASE && byteIdx == 3'h4 && writeReady;
    assign progGo     = progCmd && !progHit;
    assign eraseGo    = eraseCmd && !eraseHit;
    assign opDone     = busy && countReg == 12'h1;
    assign suspendGo  = endCmd && cmdReg == CMD_SUSPEND && busy && (opKind == OP_PROG || opKind == OP_ERASE);
    assign resumeGo   = endCmd && cmdReg == CMD_RESUME && (eraseSuspReg || progSuspReg);
    assign softGo     = endCmd && cmdReg == CMD_SOFT_RESET && !busy;
    assign clearGo    = endCmd && cmdReg == CMD_CLEAR_ERR && !busy;

    // Command capture and address tracking
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cmdReg    <= 8'h00;
            byteIdx   <= 3'h0;
            addrReg   <= 24'h0;
            wrAddrReg <= 24'h0;
            dataOne   <= 8'h00;
            dataTwo   <= 8'h00;
            dataThree <= 8'h00;
        end else if (frameEnd) begin
            byteIdx <= 3'h0;
        end else if (rxValid) begin
            if (byteIdx != 3'h7) begin
                byteIdx <= byteIdx + 3'h1;
            end
            if (byteIdx == 3'h0) begin
                cmdReg <= rxByte;
            end
            if (byteIdx >= 3'h1 && byteIdx <= 3'h3) begin
                addrReg <= {addrReg[15:0], rxByte};
            end
            if (byteIdx == 3'h3) begin
                wrAddrReg <= {addrReg[15:0], rxByte};
            end else if (byteIdx >= 3'h4) begin
                if (pageWrap512) begin
                    wrAddrReg <= {wrAddrReg[23:9], wrAddrReg[8:0] + 9'h1};
                end else begin
                    wrAddrReg <= {wrAddrReg[23:8], wrAddrReg[7:0] + 8'h1};
                end
            end
            if (byteIdx == 3'h1) begin
                dataOne <= rxByte;
            end
            if (byteIdx == 3'h2) begin
                dataTwo <= rxByte;
            end
            if (byteIdx == 3'h3) begin
                dataThree <= rxByte;
            end
        end
    end

    // Write-enable latch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            welReg <= 1'b0;
        end else if (endCmd && !busy) begin
            if (cmdReg == CMD_WRITE_EN) begin
                welReg <= 1'b1;
            end else if (cmdReg == CMD_WRITE_DIS || cmdReg == CMD_SOFT_RESET) begin
                welReg <= 1'b0;
            end
        end
    end

    // Register contents; one-time bits can only be set, except the freeze bit, which soft reset clears
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            disableReg <= 1'b0;
            protReg    <= PROT_RESET;
            configReg  <= CONFIG_RESET;
            s2OtpReg   <= S2_OTP_RESET;
        end else if (softGo) begin
            configReg[C1_FREEZE] <= 1'b0;
            if (configReg[C1_VOLATILE]) begin
                protReg <= PROT_VOL_RESET;
            end
        end else if (regsGo) begin
            disableReg <= dataOne[S1_DISABLE];
            if (!configReg[C1_FREEZE]) begin
                protReg <= dataOne[S1_PROT_HI:S1_PROT_LO];
            end
            if (byteIdx >= 3'h3) begin
                configReg[C1_LAT_HI:C1_LAT_LO] <= dataTwo[C1_LAT_HI:C1_LAT_LO];
                configReg[C1_QUAD]     <= dataTwo[C1_QUAD];
                configReg[C1_VOLATILE] <= configReg[C1_VOLATILE] | dataTwo[C1_VOLATILE];
                configReg[C1_FREEZE]   <= configReg[C1_FREEZE] | dataTwo[C1_FREEZE];
                if (!configReg[C1_FREEZE]) begin
                    configReg[C1_ORIGIN] <= configReg[C1_ORIGIN] | dataTwo[C1_ORIGIN];
                    configReg[C1_PARAM]  <= configReg[C1_PARAM] | dataTwo[C1_PARAM];
                end
            end
            if (byteIdx >= 3'h4) begin
                s2OtpReg <= s2OtpReg | dataThree[S2_OTP_HI:S2_OTP_LO];
            end
        end
    end

    // Operation timer with suspend and resume
    // Busy is kept as a flop that tracks an owned, unsuspended timer, so the pin is glitch free
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            opKind       <= OP_NONE;
            countReg     <= 12'h0;
            eraseSuspReg <= 1'b0;
            progSuspReg  <= 1'b0;
            busy         <= 1'b0;
        end else if (regsGo) begin
            opKind   <= OP_REGS;
            countReg <= REGS_CYCLES;
            busy     <= 1'b1;
        end else if (progGo) begin
            opKind   <= OP_PROG;
            countReg <= PROG_CYCLES;
            busy     <= 1'b1;
        end else if (eraseGo) begin
            opKind   <= OP_ERASE;
            countReg <= ERASE_CYCLES;
            busy     <= 1'b1;
        end else if (suspendGo) begin
            eraseSuspReg <= opKind == OP_ERASE;
            progSuspReg  <= opKind == OP_PROG;
            busy         <= 1'b0;
        end else if (resumeGo) begin
            eraseSuspReg <= 1'b0;
            progSuspReg  <= 1'b0;
            busy         <= 1'b1;
        end else if (busy) begin
            if (opDone) begin
                opKind <= OP_NONE;
                busy   <= 1'b0;
            end
            countReg <= countReg - 12'h1;
        end
    end

    // Error flags: a setting event wins over a clear in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            progErrReg  <= 1'b0;
            eraseErrReg <= 1'b0;
        end else begin
            if ((opDone && opKind == OP_PROG && opFail) || (progCmd && progHit)) begin
                progErrReg <= 1'b1;
            end else if (clearGo || softGo) begin
                progErrReg <= 1'b0;
            end
            if ((opDone && opKind == OP_ERASE && opFail) || (eraseCmd && eraseHit)) begin
                eraseErrReg <= 1'b1;
            end else if (clearGo || softGo) begin
                eraseErrReg <= 1'b0;
            end
        end
    end

    // Array requests; data reaches the array only for an accepted program
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            arrayWrite   <= 1'b0;
            arrayStart   <= 1'b0;
            arrayEraseOp <= 1'b0;
            arrayAddr    <= 24'h0;
            arrayData    <= 8'h00;
        end else begin
            arrayWrite <= 1'b0;
            arrayStart <= 1'b0;
            if (rxValid && !frameEnd && cmdReg == CMD_PROGRAM && byteIdx >= 3'h4 && writeReady && !progHit) begin
                arrayWrite <= 1'b1;
                arrayAddr  <= wrAddrReg;
                arrayData  <= rxByte;
            end
            if (progGo || eraseGo) begin
                arrayStart   <= 1'b1;
                arrayEraseOp <= eraseGo;
                arrayAddr    <= eraseGo ? eraseAddr : addrReg;
            end
        end
    end

    chk_latch_source: assert property (@(posedge clock) disable iff (reset)
        $changed(welReg) |-> $past(endCmd) && ($past(cmdReg) == CMD_WRITE_EN || $past(cmdReg) == CMD_WRITE_DIS
                                              || $past(cmdReg) == CMD_SOFT_RESET))
        else $error("Latch changed without enable or disable");

    chk_hw_lock: assert property (@(posedge clock) disable iff (reset)
        frameEnd && cmdReg == CMD_WRITE_REGS && disableReg && !wpLevel
        |=> $stable(protReg) && $stable(disableReg) && $stable(configReg) && opKind == $past(opKind))
        else $error("Register write taken while hardware locked");

    chk_start_gate: assert property (@(posedge clock) disable iff (reset)
        arrayStart |-> $past(welReg, 1) && $past(opKind) == OP_NONE)
        else $error("Array start without write enable");

    chk_busy_run: assert property (@(posedge clock) disable iff (reset)
        arrayStart |-> busy ##1 busy[*8])
        else $error("Busy not held during operation");

    chk_range_block: assert property (@(posedge clock) disable iff (reset)
        arrayStart |-> !inRange(arrayAddr, protReg, configReg[C1_ORIGIN]))
        else $error("Started operation inside protected range");

    chk_prog_error: assert property (@(posedge clock) disable iff (reset)
        opDone && opKind == OP_PROG && opFail |=> progErrReg && !busy)
        else $error("Program failure not flagged");

    chk_erase_error: assert property (@(posedge clock) disable iff (reset)
        opDone && opKind == OP_ERASE && opFail |=> eraseErrReg && !busy)
        else $error("Erase failure not flagged");

    chk_freeze_lock: assert property (@(posedge clock) disable iff (reset)
        configReg[C1_FREEZE] && !softGo |=> $stable(protReg) && $stable(configReg[C1_ORIGIN])
                                            && $stable(configReg[C1_PARAM]))
        else $error("Frozen bits changed");

    chk_erase_susp: assert property (@(posedge clock) disable iff (reset)
        suspendGo && opKind == OP_ERASE |=> eraseSuspReg && !busy && statusTwo[1])
        else $error("Erase suspend not reported");

    chk_erase_align: assert property (@(posedge clock) disable iff (reset)
        arrayStart && arrayEraseOp |-> (uniformErase ? arrayAddr[17:0] == 18'h0 : arrayAddr[15:0] == 16'h0))
        else $error("Erase address not sector aligned");

endmodule

/* tb/spi_host_model.sv */
// Host side of the serial link: mode 0 frames, MSB first.
// Assumes the device shifts out after each fall, so rises sample settled data.
`timescale 1ns/1ps
module spi_host_model (
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] rdByte;
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end
    // Sends n leading bytes of tx; the last byte seen on miso lands in rdByte
    task automatic frame(input logic [39:0] tx, input int n);
        csN = 1'b0;
        for (int i = 39; i >= 40 - 8 * n; i--) begin
            mosi = tx[i];
            #80 sclk = 1'b1;
            rdByte = {rdByte[6:0], miso};
            #80 sclk = 1'b0;
        end
        #80 csN = 1'b1;
        // Toggle on release so a stale bit never looks valid
        mosi = ~mosi;
        #100;
    endtask
endmodule

/* tb/flash_status_regs_tb.sv */
// Testbench for the flash status and configuration register bank.
// Assumes the host model on the serial pins; the bench drives wpN and opFail.
`timescale 1ns/1ps
module flash_status_regs_tb
    import flash_regs_pkg::*;
;
    logic        clock;
    logic        reset;
    logic        wpN;
    logic        opFail;
    logic        sclk;
    logic        csN;
    logic        mosi;
    logic        miso;
    logic        misoOe;
    logic        busy;
    logic        quadEnable;
    logic [1:0]  latencyCode;
    logic        protectOriginLow;
    logic        paramSectorsTop;
    logic        otpLocked;
    logic        uniformErase;
    logic        pageWrap512;
    logic        line3ResetFunction;
    logic        arrayWrite;
    logic        arrayStart;
    logic        arrayEraseOp;
    logic [23:0] arrayAddr;
    logic [7:0]  arrayData;
    logic [23:0] startAddr;
    logic        startKind;
    logic [23:0] wrAddr;
    logic [7:0]  wrData;
    logic        oeSeen;
    int          starts;
    int          err_count;
    int          total_checks;

    flash_status_regs DUT (.clock(clock), .reset(reset), .sclk(sclk), .csN(csN), .mosi(mosi), .wpN(wpN),
        .opFail(opFail), .miso(miso), .misoOe(misoOe), .busy(busy), .quadEnable(quadEnable),
        .latencyCode(latencyCode), .protectOriginLow(protectOriginLow), .paramSectorsTop(paramSectorsTop),
        .otpLocked(otpLocked), .uniformErase(uniformErase), .pageWrap512(pageWrap512),
        .line3ResetFunction(line3ResetFunction), .arrayWrite(arrayWrite), .arrayStart(arrayStart),
        .arrayEraseOp(arrayEraseOp), .arrayAddr(arrayAddr), .arrayData(arrayData));
    spi_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Array requests are one-cycle pulses, so they are latched here for later compares
    always @(posedge clock) begin
        if (misoOe) begin
            oeSeen <= 1'b1;
        end
        if (arrayStart) begin
            starts    <= starts + 1;
            startAddr <= arrayAddr;
            startKind <= arrayEraseOp;
        end
        if (arrayWrite) begin
            wrAddr <= arrayAddr;
            wrData <= arrayData;
        end
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkReg(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        host.frame({cmd, 32'h0}, 2);
        chk(what, exp, host.rdByte);
    endtask
    task automatic setPins(input logic wp, input logic fail);
        @(posedge clock);
        wpN    <= wp;
        opFail <= fail;
        @(negedge clock);
    endtask
    // Polls busy over the link; a device stuck busy ends the run
    task automatic waitIdle();
        for (int i = 0; i < 30; i++) begin
            host.frame({CMD_READ_S1, 32'h0}, 2);
            if (host.rdByte[0] === 1'b0) return;
        end
        err_count++;
        end_of_test();
    endtask

    task automatic t_reset();
        chkReg("status_one", CMD_READ_S1, 8'h00);
        chkReg("config_one", CMD_READ_CONFIG, 8'h00);
        chkReg("status_two", CMD_READ_S2, 8'h00);
        chk("misoOe", 8'h01, {6'h0, misoOe, oeSeen});
    endtask
    task automatic t_latch();
        host.frame({CMD_WRITE_REGS, 8'h9c, 8'hc2, 16'h0}, 3);
        chkReg("config_one", CMD_READ_CONFIG, 8'h00);
        chkReg("status_one", CMD_READ_S1, 8'h00);
        host.frame({CMD_WRITE_EN, 32'h0}, 1);
        chkReg("status_one", CMD_READ_S1, 8'h02);
    endtask
    // Reserved bits are written as ones and must read back clear
    task automatic t_write();
        host.frame({CMD_WRITE_REGS, 8'h00, 8'hd2, 8'hbc, 8'h00}, 4);
        chk("busy", 8'h01, {7'h0, busy});
        waitIdle();
        chkReg("status_one", CMD_READ_S1, 8'h02);
        chkReg("config_one", CMD_READ_CONFIG, 8'hc2);
        chkReg("status_two", CMD_READ_S2, 8'ha0);
        chk("quadEnable", 8'h01, {7'h0, quadEnable});
        chk("latencyCode", 8'h03, {6'h0, latencyCode});
        chk("options", 8'h05, {5'h0, uniformErase, pageWrap512, line3ResetFunction});
    endtask
    task automatic t_fail();
        setPins(1'b1, 1'b1);
        host.frame({CMD_PROGRAM, 24'h000100, 8'h55}, 5);
        waitIdle();
        chkReg("status_one", CMD_READ_S1, 8'h42);
        host.frame({CMD_BLOCK_ERASE, 24'h000000, 8'h00}, 4);
        chk("busy", 8'h01, {7'h0, busy});
        waitIdle();
        chkReg("status_one", CMD_READ_S1, 8'h62);
        setPins(1'b1, 1'b0);
    endtask
    // Suspend holds the timer and clears busy until resume
    task automatic t_suspend();
        host.frame({CMD_BLOCK_ERASE, 24'h04abcd, 8'h00}, 4);
        chk("startAddr", 24'h040000, startAddr);
        chk("startKind", 8'h01, {7'h0, startKind});
        host.frame({CMD_SUSPEND, 32'h0}, 1);
        chk("busy", 8'h00, {7'h0, busy});
        chkReg("status_two", CMD_READ_S2, 8'ha2);
        host.frame({CMD_RESUME, 32'h0}, 1);
        waitIdle();
        chkReg("status_two", CMD_READ_S2, 8'ha0);
        host.frame({CMD_PROGRAM, 24'h000300, 8'h3c}, 5);
        host.frame({CMD_SUSPEND, 32'h0}, 1);
        chkReg("status_two", CMD_READ_S2, 8'ha1);
        host.frame({CMD_RESUME, 32'h0}, 1);
        waitIdle();
        chk("wrAddr", 24'h000300, wrAddr);
        chk("wrData", 8'h3c, wrData);
        chk("startAddr", 24'h000300, startAddr);
    endtask
    // The lock needs both the disable bit and a low protect pin
    task automatic t_lock();
        host.frame({CMD_WRITE_REGS, 8'h80, 8'hc2, 16'h0}, 3);
        waitIdle();
        setPins(1'b0, 1'b0);
        host.frame({CMD_WRITE_REGS, 8'h00, 8'hc0, 16'h0}, 3);
        chk("busy", 8'h00, {7'h0, busy});
        chkReg("status_one", CMD_READ_S1, 8'he2);
        chkReg("config_one", CMD_READ_CONFIG, 8'hc2);
        setPins(1'b1, 1'b0);
    endtask
    // Protection from the low end, freeze, latch off, then soft resets
    task automatic t_protect();
        int n;
        host.frame({CMD_CLEAR_ERR, 32'h0}, 1);
        host.frame({CMD_WRITE_REGS, 8'h08, 8'h24, 16'h0}, 3);
        waitIdle();
        chkReg("status_one", CMD_READ_S1, 8'h0a);
        chk("origin", 8'h03, {6'h0, protectOriginLow, paramSectorsTop});
        n = starts;
        host.frame({CMD_PROGRAM, 24'h07ff00, 8'h11}, 5);
        chkReg("status_one", CMD_READ_S1, 8'h4a);
        host.frame({CMD_PROGRAM, 24'h080000, 8'h22}, 5);
        waitIdle();
        chk("starts", 24'(n + 1), 24'(starts));
        chk("startAddr", 24'h080000, startAddr);
        host.frame({CMD_WRITE_REGS, 8'h08, 8'h25, 16'h0}, 3);
        waitIdle();
        host.frame({CMD_WRITE_REGS, 8'h1c, 8'h00, 16'h0}, 3);
        waitIdle();
        chkReg("status_one", CMD_READ_S1, 8'h4a);
        chkReg("config_one", CMD_READ_CONFIG, 8'h25);
        chk("otpLocked", 8'h01, {7'h0, otpLocked});
        host.frame({CMD_WRITE_DIS, 32'h0}, 1);
        n = starts;
        host.frame({CMD_PROGRAM, 24'h100000, 8'h33}, 5);
        chk("starts", 24'(n), 24'(starts));
        chkReg("status_one", CMD_READ_S1, 8'h48);
        host.frame({CMD_SOFT_RESET, 32'h0}, 1);
        chkReg("status_one", CMD_READ_S1, 8'h08);
        chkReg("config_one", CMD_READ_CONFIG, 8'h24);
        host.frame({CMD_WRITE_EN, 32'h0}, 1);
        host.frame({CMD_WRITE_REGS, 8'h08, 8'h2c, 16'h0}, 3);
        waitIdle();
        host.frame({CMD_SOFT_RESET, 32'h0}, 1);
        chkReg("status_one", CMD_READ_S1, 8'h1c);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        err_count    = 0;
        total_checks = 0;
        starts       = 0;
        oeSeen       = 1'b0;
        reset        = 1'b1;
        wpN          = 1'b1;
        opFail       = 1'b0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(negedge clock);
        t_reset();
        t_latch();
        t_write();
        t_fail();
        t_suspend();
        t_lock();
        t_protect();
        end_of_test();
    end
endmodule
